/* File: fcic_map.vh */
// Purpose: constants of the flag/clear/invert/compare execution block
// Assumes: included by bare name from every design file
// Notes: definitions only
//
// Overview of operation
// - Carry invert (EF) is one byte, 4 cycles, flips carry, keeps others.
// - The carry these operations use lives in the flags register at 0D5.
// - Zero fill (B0 direct, B1 via pointer) writes 0, 2 bytes, 4 cycles.
// - Pointer mode uses a register's contents as operand address only.
// - Invert (60 direct, 61 via pointer) writes NOT dst, 2 bytes, 4 cyc.
// - Invert sets zero and sign from result, clears overflow, keeps rest.
// - Compare computes dst minus src for the flags only, no writeback.
// - Compare forms A2 (2B,4c), A3 (6c), A4/A5/A6 (3 bytes, 6 cycles).
// - Compare sets carry on borrow (src above dst), clears otherwise.
// - Compare sets zero, sign, signed overflow; keeps D and H flags.
// - Compare flags always reflect destination minus source.
`ifndef FCIC_MAP_VH
`define FCIC_MAP_VH

// =====================================================================
// opcodes
`define FCIC_OP_CINV 8'hEF
`define FCIC_OP_ZF_R 8'hB0
`define FCIC_OP_ZF_IR 8'hB1
`define FCIC_OP_INV_R 8'h60
`define FCIC_OP_INV_IR 8'h61
`define FCIC_OP_CMP_WW 8'hA2
`define FCIC_OP_CMP_WI 8'hA3
`define FCIC_OP_CMP_RR 8'hA4
`define FCIC_OP_CMP_RI 8'hA5
`define FCIC_OP_CMP_RL 8'hA6

// =====================================================================
// lengths and cycle counts
`define FCIC_LEN_1 2'h1
`define FCIC_LEN_2 2'h2
`define FCIC_LEN_3 2'h3
`define FCIC_CYC_SHORT 4'h4
`define FCIC_CYC_LONG 4'h6

// =====================================================================
// flags register: location and bit positions
`define FCIC_FLAGS_IDX 8'hD5
`define FCIC_FLAGS_RST 8'h00
`define FCIC_FLG_C 7
`define FCIC_FLG_Z 6
`define FCIC_FLG_S 5
`define FCIC_FLG_V 4
`define FCIC_FLG_D 3
`define FCIC_FLG_H 2

// working registers r0..r15 sit at this upper nibble
`define FCIC_WREG_BASE 4'hC

// =====================================================================
// bus map: register n of the file at byte 4*n, control words above
`define FCIC_WIN_TOP 12'h3FC
`define FCIC_CMD_ADDR 12'h400
`define FCIC_STAT_ADDR 12'h404
`define FCIC_CMD_RST 24'h000000

`endif

/* File: fcic_regfile.v */
// Purpose: 256-entry register file with a separate flags register
// Assumes: single clock, synchronous active-high reset
// Notes: three combinational read ports; the file itself is not reset
`timescale 1ns/100ps
`default_nettype none
`include "fcic_map.vh"

module fcic_regfile #(
    parameter DEPTH = 256
) (
    input wire clk,
    input wire rst,
    input wire [7:0] rdAddrA,
    input wire [7:0] rdAddrB,
    input wire [7:0] rdAddrC,
    output wire [7:0] rdDataA,
    output wire [7:0] rdDataB,
    output wire [7:0] rdDataC,
    input wire wrEn,
    input wire [7:0] wrAddr,
    input wire [7:0] wrData,
    input wire flgWrEn,
    input wire [7:0] flgWrData,
    output wire [7:0] flagsOut
);

    reg [7:0] mem [0:DEPTH-1];
    reg [7:0] flags_r;

    // =================================================================
    // flags register decoded out of the file
    always @(posedge clk) begin
        if (rst) begin
            flags_r <= `FCIC_FLAGS_RST;
        end else if (wrEn && wrAddr == `FCIC_FLAGS_IDX) begin
            // explicit destination write beats the flag update
            flags_r <= wrData;
        end else if (flgWrEn) begin
            flags_r <= flgWrData;
        end
    end

    always @(posedge clk) begin
        if (wrEn && wrAddr != `FCIC_FLAGS_IDX) begin
            mem[wrAddr] <= wrData;
        end
    end

    assign rdDataA = (rdAddrA == `FCIC_FLAGS_IDX) ? flags_r : mem[rdAddrA];
    assign rdDataB = (rdAddrB == `FCIC_FLAGS_IDX) ? flags_r : mem[rdAddrB];
    assign rdDataC = (rdAddrC == `FCIC_FLAGS_IDX) ? flags_r : mem[rdAddrC];
    assign flagsOut = flags_r;

endmodule // fcic_regfile

`default_nettype wire

/* File: fcic_alu.v */
// Purpose: result and flag logic of the four supported operations
// Assumes: operands already fetched; purely combinational
// Notes: known low for any opcode outside the supported set
`timescale 1ns/100ps
`default_nettype none
`include "fcic_map.vh"

module fcic_alu (
    input wire [7:0] opcode,
    input wire [7:0] dstVal,
    input wire [7:0] srcVal,
    input wire [7:0] flagsIn,
    output reg [7:0] result,
    output reg [7:0] flagsOut,
    output reg wrResult,
    output reg wrFlags,
    output reg known
);

    // 9-bit so bit 8 is the borrow out
    wire [8:0] diff = {1'b0, dstVal} - {1'b0, srcVal};
    wire [7:0] inv = ~dstVal;

    always @* begin
        result = 8'h00;
        flagsOut = flagsIn;
        wrResult = 1'b0;
        wrFlags = 1'b0;
        known = 1'b1;
        case (opcode)
            `FCIC_OP_CINV: begin
                flagsOut[`FCIC_FLG_C] = ~flagsIn[`FCIC_FLG_C];
                wrFlags = 1'b1;
            end
            `FCIC_OP_ZF_R, `FCIC_OP_ZF_IR: begin
                result = 8'h00;
                wrResult = 1'b1;
            end
            `FCIC_OP_INV_R, `FCIC_OP_INV_IR: begin
                result = inv;
                wrResult = 1'b1;
                wrFlags = 1'b1;
                flagsOut[`FCIC_FLG_Z] = (inv == 8'h00);
                flagsOut[`FCIC_FLG_S] = inv[7];
                flagsOut[`FCIC_FLG_V] = 1'b0;
            end
            `FCIC_OP_CMP_WW, `FCIC_OP_CMP_WI, `FCIC_OP_CMP_RR,
            `FCIC_OP_CMP_RI, `FCIC_OP_CMP_RL: begin
                wrFlags = 1'b1;
                flagsOut[`FCIC_FLG_C] = diff[8];
                flagsOut[`FCIC_FLG_Z] = (diff[7:0] == 8'h00);
                flagsOut[`FCIC_FLG_S] = diff[7];
                flagsOut[`FCIC_FLG_V] = (dstVal[7] ^ srcVal[7]) &
                    (dstVal[7] ^ diff[7]);
            end
            default: begin
                known = 1'b0;
            end
        endcase
    end

endmodule // fcic_alu

`default_nettype wire

/* File: fcic_core.v */
// Purpose: AHB-Lite slave, operation sequencer and register file glue
// Assumes: one clock, synchronous reset, single-word AHB transfers
// Notes: the command word starts an operation; results land in the file
`timescale 1ns/100ps
`default_nettype none
`include "fcic_map.vh"

module fcic_core (
    input wire clk,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire [31:0] hrdata,
    output wire hresp,
    output wire busy
);

    // =================================================================
    // sequencer states
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_ADDR = 2'b01;
    localparam [1:0] ST_OPER = 2'b10;
    localparam [1:0] ST_HOLD = 2'b11;

    reg [1:0] state_r;
    reg [3:0] cycLeft_r;
    reg [23:0] cmd_r;
    reg [7:0] op_r;
    reg [7:0] b2_r;
    reg [7:0] b3_r;
    reg [7:0] dstEa_r;
    reg [7:0] srcEa_r;
    reg [7:0] res_r;
    reg [7:0] flg_r;
    reg wrRes_r;
    reg wrFlg_r;
    reg err_r;
    reg [1:0] lastLen_r;
    reg [3:0] lastCyc_r;
    reg [7:0] lastRes_r;
    // busy straight from a flop, in step with the state register
    reg busy_r;

    // bus data phase
    reg pend_r;
    reg pWrite_r;
    reg pMapped_r;
    reg [11:0] pAddr_r;
    reg rdDone_r;
    reg [31:0] hrdata_r;

    wire [7:0] rdDataA;
    wire [7:0] rdDataB;
    wire [7:0] rdDataC;
    wire [7:0] flagsNow;
    wire [7:0] aluRes;
    wire [7:0] aluFlg;
    wire aluWrRes;
    wire aluWrFlg;
    wire aluKnown;

    // =================================================================
    // bus slave
    // only bits 11:2 decode; anything set above bit 11 is unmapped
    wire addrPhase = hsel & htrans[1] & hready;
    wire tgtStat = pMapped_r & (pAddr_r == `FCIC_STAT_ADDR);
    wire tgtWin = pMapped_r & (pAddr_r <= `FCIC_WIN_TOP);
    wire tgtCmd = pMapped_r & (pAddr_r == `FCIC_CMD_ADDR);
    // file and command accesses wait out a running operation, so the
    // file never sees two writers in one cycle
    wire stall = pend_r & (state_r != ST_IDLE) & pMapped_r & ~tgtStat;
    wire rdy = ~pend_r | (~stall & (pWrite_r | rdDone_r));
    wire done = pend_r & rdy;
    wire busWrWin = done & pWrite_r & tgtWin;
    wire start = done & pWrite_r & tgtCmd;

    assign hreadyout = rdy;
    assign hrdata = hrdata_r;
    assign hresp = 1'b0;
    assign busy = busy_r;

    always @(posedge clk) begin
        if (rst) begin
            pend_r <= 1'b0;
            pWrite_r <= 1'b0;
            pMapped_r <= 1'b0;
            pAddr_r <= 12'h000;
        end else if (addrPhase) begin
            pend_r <= 1'b1;
            pWrite_r <= hwrite;
            pMapped_r <= (haddr[31:12] == 20'h00000);
            pAddr_r <= {haddr[11:2], 2'b00};
        end else if (done) begin
            pend_r <= 1'b0;
        end
    end

    // status: last result, cycle count, length, error, busy
    wire [31:0] statWord = {8'h00, lastRes_r, 4'h0, lastCyc_r, 2'b00,
                            lastLen_r, 2'b00, err_r, busy};

    reg [31:0] rdMux;
    always @* begin
        rdMux = 32'h00000000;
        if (tgtWin) begin
            rdMux = {24'h000000, rdDataC};
        end else if (tgtCmd) begin
            rdMux = {8'h00, cmd_r};
        end else if (tgtStat) begin
            rdMux = statWord;
        end
    end

    // one wait state on reads so read data comes from a flop
    always @(posedge clk) begin
        if (rst) begin
            rdDone_r <= 1'b0;
            hrdata_r <= 32'h00000000;
        end else if (pend_r & ~pWrite_r & ~stall & ~rdDone_r) begin
            rdDone_r <= 1'b1;
            hrdata_r <= rdMux;
        end else if (done) begin
            rdDone_r <= 1'b0;
        end
    end

    // =================================================================
    // decode of the latched command
    wire isPtrDst = (op_r == `FCIC_OP_ZF_IR) | (op_r == `FCIC_OP_INV_IR);
    wire isWork = (op_r == `FCIC_OP_CMP_WW) | (op_r == `FCIC_OP_CMP_WI);
    wire isRegCmp = (op_r == `FCIC_OP_CMP_RR) | (op_r == `FCIC_OP_CMP_RI);
    wire isLit = (op_r == `FCIC_OP_CMP_RL);
    wire isPtrSrc = (op_r == `FCIC_OP_CMP_WI) | (op_r == `FCIC_OP_CMP_RI);
    // A2/A3 name two working registers in the nibbles of byte two
    wire [7:0] wDst = {`FCIC_WREG_BASE, b2_r[7:4]};
    wire [7:0] wSrc = {`FCIC_WREG_BASE, b2_r[3:0]};
    // pointer registers named by the operand bytes
    wire [7:0] dstPtr = isWork ? wDst : (isRegCmp ? b3_r : b2_r);
    wire [7:0] srcPtr = isWork ? wSrc : b2_r;

    // length and cycle count per opcode, kept for the status word
    reg [1:0] lenNxt;
    reg [3:0] cycNxt;
    always @* begin
        lenNxt = `FCIC_LEN_2;
        cycNxt = `FCIC_CYC_SHORT;
        case (cmd_r[7:0])
            `FCIC_OP_CINV: begin
                lenNxt = `FCIC_LEN_1;
            end
            `FCIC_OP_ZF_R, `FCIC_OP_ZF_IR, `FCIC_OP_INV_R,
            `FCIC_OP_INV_IR, `FCIC_OP_CMP_WW: begin
                lenNxt = `FCIC_LEN_2;
            end
            `FCIC_OP_CMP_WI: begin
                cycNxt = `FCIC_CYC_LONG;
            end
            `FCIC_OP_CMP_RR, `FCIC_OP_CMP_RI, `FCIC_OP_CMP_RL: begin
                lenNxt = `FCIC_LEN_3;
                cycNxt = `FCIC_CYC_LONG;
            end
            default: begin
                // unknown opcodes run the short count and write nothing
                lenNxt = `FCIC_LEN_1;
            end
        endcase
    end

    // =================================================================
    // register file ports: port A dst side, B src side, C the bus
    reg [7:0] rdAddrA;
    reg [7:0] rdAddrB;
    always @* begin
        rdAddrA = dstEa_r;
        rdAddrB = srcEa_r;
        if (state_r == ST_ADDR) begin
            rdAddrA = b2_r;
            rdAddrB = srcPtr;
        end
    end

    // last HOLD cycle: file and flags take the same edge
    wire commit = (state_r == ST_HOLD) & (cycLeft_r == 4'h1);
    // the bus never writes here then, as it is stalled while busy
    wire fileWr = busWrWin | (commit & wrRes_r);
    wire [7:0] fileWrAddr = busWrWin ? pAddr_r[9:2] : dstEa_r;
    wire [7:0] fileWrData = busWrWin ? hwdata[7:0] : res_r;
    // literal compare takes its subtrahend from byte three
    wire [7:0] srcVal = isLit ? b3_r : rdDataB;

    fcic_regfile #(
        .DEPTH(256)
    ) u_file (
        .clk(clk),
        .rst(rst),
        .rdAddrA(rdAddrA),
        .rdAddrB(rdAddrB),
        .rdAddrC(pAddr_r[9:2]),
        .rdDataA(rdDataA),
        .rdDataB(rdDataB),
        .rdDataC(rdDataC),
        .wrEn(fileWr),
        .wrAddr(fileWrAddr),
        .wrData(fileWrData),
        .flgWrEn(commit & wrFlg_r),
        .flgWrData(flg_r),
        .flagsOut(flagsNow)
    );

    fcic_alu u_alu (
        .opcode(op_r),
        .dstVal(rdDataA),
        .srcVal(srcVal),
        .flagsIn(flagsNow),
        .result(aluRes),
        .flagsOut(aluFlg),
        .wrResult(aluWrRes),
        .wrFlags(aluWrFlg),
        .known(aluKnown)
    );

    // =================================================================
    // sequencer
    always @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cycLeft_r <= 4'h0;
            cmd_r <= `FCIC_CMD_RST;
            op_r <= 8'h00;
            b2_r <= 8'h00;
            b3_r <= 8'h00;
            dstEa_r <= 8'h00;
            srcEa_r <= 8'h00;
            res_r <= 8'h00;
            flg_r <= 8'h00;
            wrRes_r <= 1'b0;
            wrFlg_r <= 1'b0;
            err_r <= 1'b0;
            lastLen_r <= 2'b00;
            lastCyc_r <= 4'h0;
            lastRes_r <= 8'h00;
            busy_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        cmd_r <= hwdata[23:0];
                        op_r <= hwdata[7:0];
                        b2_r <= hwdata[15:8];
                        b3_r <= hwdata[23:16];
                        state_r <= ST_ADDR;
                        busy_r <= 1'b1;
                    end
                end
                ST_ADDR: begin
                    // cycles still to run after this one
                    cycLeft_r <= cycNxt - 4'h1;
                    lastLen_r <= lenNxt;
                    lastCyc_r <= cycNxt;
                    // pointer contents become the operand address only;
                    // the pointer itself is never a write target
                    dstEa_r <= isPtrDst ? rdDataA : dstPtr;
                    srcEa_r <= isPtrSrc ? rdDataB : srcPtr;
                    state_r <= ST_OPER;
                end
                ST_OPER: begin
                    cycLeft_r <= cycLeft_r - 4'h1;
                    res_r <= aluRes;
                    flg_r <= aluFlg;
                    // compare never writes an operand back
                    wrRes_r <= aluWrRes;
                    wrFlg_r <= aluWrFlg;
                    err_r <= ~aluKnown;
                    state_r <= ST_HOLD;
                end
                ST_HOLD: begin
                    cycLeft_r <= cycLeft_r - 4'h1;
                    if (cycLeft_r == 4'h1) begin
                        // result and flags land in the same edge
                        lastRes_r <= res_r;
                        wrRes_r <= 1'b0;
                        wrFlg_r <= 1'b0;
                        state_r <= ST_IDLE;
                        busy_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

endmodule // fcic_core

`default_nettype wire

/* File: fcic_core_monitor.sv */
// Purpose: bus-side checker for the fcic execution block
// Assumes: hready of the bus equals hreadyout of the block
// Notes: sees the top ports only, attached by bind
`timescale 1ns/100ps
`default_nettype none
`include "fcic_map.vh"

module fcic_core_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic busy
);
    logic cmdPend_r;
    logic filePend_r;
    logic take;
    logic launch;
    logic [7:0] op;
    assign take = hsel && htrans[1] && hready;
    // an operation starts at the edge closing the command data phase
    assign launch = cmdPend_r && hreadyout;
    assign op = hwdata[7:0];

    always_ff @(posedge clk) begin
        if (rst) begin
            cmdPend_r <= 1'b0;
            filePend_r <= 1'b0;
        end else if (hready) begin
            cmdPend_r <= take && hwrite && haddr == {20'h0, `FCIC_CMD_ADDR};
            filePend_r <= take && haddr[31:10] == 22'h0;
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);

    // =====================================================================
    // operation lengths
    a_carry_len:
    assert property (launch && op == `FCIC_OP_CINV |=> busy[*4] ##1 !busy)
        else $error("carry invert length wrong");
    a_fill_len:
    assert property (launch && (op == `FCIC_OP_ZF_R || op == `FCIC_OP_ZF_IR)
        |=> busy[*4] ##1 !busy) else $error("zero fill length wrong");
    a_invert_len:
    assert property (launch && (op == `FCIC_OP_INV_R || op == `FCIC_OP_INV_IR)
        |=> busy[*4] ##1 !busy) else $error("invert length wrong");
    a_cmp_short:
    assert property (launch && op == `FCIC_OP_CMP_WW |=> busy[*4] ##1 !busy)
        else $error("short compare length wrong");
    a_cmp_long:
    assert property (launch && op >= `FCIC_OP_CMP_WI && op <= `FCIC_OP_CMP_RL
        |=> busy[*6] ##1 !busy) else $error("long compare length wrong");

    // =====================================================================
    // nothing half done is visible
    a_busy_cause:
    assert property ($rose(busy) |-> $past(launch))
        else $error("busy rose without a command");
    a_file_stall:
    assert property (filePend_r && busy |-> !hreadyout)
        else $error("file access completed while busy");
    a_cmd_stall:
    assert property (cmdPend_r && busy |-> !hreadyout)
        else $error("command taken while busy");

    c_carry: cover property (launch && op == `FCIC_OP_CINV);
    c_cmp_ptr: cover property (launch && op == `FCIC_OP_CMP_RI);
    c_stall: cover property (filePend_r && busy);
endmodule // fcic_core_monitor

bind fcic_core fcic_core_monitor u_mon (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .busy(busy));
`default_nettype wire

/* File: flag_clear_invert_compare_ops_tb.sv */
// Purpose: self-checking bench of the fcic execution block
// Assumes: one AHB-Lite master, hready tied to hreadyout
// Notes: file register n sits at byte 4*n, data in bits 7:0
`timescale 1ns/100ps
`default_nettype none
`include "fcic_map.vh"

module flag_clear_invert_compare_ops_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire logic hreadyout;
    wire logic [31:0] hrdata;
    wire logic hresp;
    wire logic busy;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] q;

    always #4 clk = ~clk;

    fcic_core DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .busy(busy));

    // =====================================================================
    // reporting
    task automatic give_verdict;
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // the whole run needs about a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] g, input logic [31:0] e,
                         input string what);
        checked++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: %s got %h want %h", $time, what, g, e);
        end
    endtask

    // =====================================================================
    // bus access; hready is looked at just before the edge that samples it
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(negedge clk); while (hreadyout !== 1'b1);
        @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        do @(negedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
        @(posedge clk);
    endtask

    task automatic wreg(input logic [7:0] n, input logic [7:0] v);
        xfer(1'b1, {2'h0, n, 2'h0}, {24'h0, v}, q);
    endtask

    task automatic creg(input logic [7:0] n, input logic [7:0] v,
                        input string what);
        xfer(1'b0, {2'h0, n, 2'h0}, 32'h0, q);
        check(q, {24'h0, v}, what);
    endtask

    // len 0 marks an opcode outside the set
    task automatic run(input logic [23:0] cmd, input logic [3:0] cyc,
                       input logic [1:0] len);
        int n;
        n = 0;
        xfer(1'b1, `FCIC_CMD_ADDR, {8'h0, cmd}, q);
        do begin
            @(negedge clk);
            if (busy === 1'b1) n++;
        end while (busy !== 1'b0 || n == 0);
        @(posedge clk);
        check(n, {28'h0, cyc}, "busy cycles");
        xfer(1'b0, `FCIC_STAT_ADDR, 32'h0, q);
        check(q[11:8], cyc, "status cycles");
        if (len != 2'h0) check(q[5:4], len, "status length");
        else check(q[1], 1'b1, "status error");
    endtask

    // =====================================================================
    // scenarios
    task automatic t_reset;
        creg(`FCIC_FLAGS_IDX, 8'h00, "flags at reset");
        check({31'h0, hresp}, 32'h0, "bus response");
        xfer(1'b1, 12'h800, 32'hFF, q);
        xfer(1'b0, 12'h800, 32'h0, q);
        check(q, 32'h0, "unmapped read");
    endtask

    task automatic t_carry;
        wreg(8'hD5, 8'h7C);
        run({16'h0, `FCIC_OP_CINV}, 4'h4, 2'h1);
        creg(8'hD5, 8'hFC, "carry flipped up");
        run({16'h0, `FCIC_OP_CINV}, 4'h4, 2'h1);
        creg(8'hD5, 8'h7C, "carry flipped down");
    endtask

    task automatic t_fill;
        wreg(8'hD5, 8'hA4);
        wreg(8'h10, 8'h4F);
        wreg(8'h01, 8'h02);
        wreg(8'h02, 8'h5E);
        run({8'h0, 8'h10, `FCIC_OP_ZF_R}, 4'h4, 2'h2);
        creg(8'h10, 8'h00, "direct fill");
        run({8'h0, 8'h01, `FCIC_OP_ZF_IR}, 4'h4, 2'h2);
        creg(8'h02, 8'h00, "pointed fill");
        creg(8'h01, 8'h02, "fill pointer kept");
        creg(8'hD5, 8'hA4, "fill flags kept");
    endtask

    task automatic t_invert;
        wreg(8'hD5, 8'h9C);
        wreg(8'hC1, 8'h07);
        wreg(8'h07, 8'hF1);
        run({8'h0, 8'hC1, `FCIC_OP_INV_R}, 4'h4, 2'h2);
        check(q[23:16], 8'hF8, "status result");
        creg(8'hC1, 8'hF8, "direct invert");
        creg(8'hD5, 8'hAC, "invert flags");
        wreg(8'hC1, 8'h07);
        run({8'h0, 8'hC1, `FCIC_OP_INV_IR}, 4'h4, 2'h2);
        creg(8'h07, 8'h0E, "pointed invert");
        creg(8'hC1, 8'h07, "invert pointer kept");
        creg(8'hD5, 8'h8C, "invert flags");
        wreg(8'h20, 8'hFF);
        wreg(8'hD5, 8'h10);
        run({8'h0, 8'h20, `FCIC_OP_INV_R}, 4'h4, 2'h2);
        creg(8'h20, 8'h00, "invert to zero");
        creg(8'hD5, 8'h40, "zero result flags");
    endtask

    // every compare form against each operand pair
    task automatic t_cmp;
        logic [7:0] d;
        logic [7:0] s;
        logic [7:0] df;
        logic [7:0] ef;
        logic [7:0] da;
        logic [7:0] sa;
        logic [7:0] b3;
        for (int i = 0; i < 4; i++) begin
            for (int f = 0; f < 5; f++) begin
                d = 8'(32'h02805A7F >> (8 * i));
                s = 8'(32'h03015AFF >> (8 * i));
                df = d - s;
                ef = {s > d, df == 8'h0, df[7],
                      (d[7] != s[7]) && (df[7] != d[7]), 4'hC};
                da = (f < 2) ? 8'hC1 : 8'h40;
                sa = 8'(40'hC230414344 >> (8 * (4 - f)));
                b3 = (f < 2) ? 8'h00 : ((f == 4) ? s : 8'h40);
                wreg(8'hC3, 8'h30);
                wreg(8'h42, 8'h43);
                wreg(da, d);
                wreg(sa, s);
                wreg(8'hD5, 8'hFC);
                run({b3, 8'(40'h1213414240 >> (8 * (4 - f))),
                     8'(`FCIC_OP_CMP_WW + f)}, (f == 0) ? 4'h4 : 4'h6,
                    (f < 2) ? 2'h2 : 2'h3);
                creg(8'hD5, ef, "compare flags");
                creg(da, d, "minuend kept");
                creg(sa, s, "subtrahend kept");
                creg(8'hC3, 8'h30, "compare pointer kept");
            end
        end
    endtask

    task automatic t_busy;
        wreg(8'hD5, 8'h00);
        xfer(1'b1, `FCIC_CMD_ADDR, {24'h0, `FCIC_OP_CINV}, q);
        xfer(1'b0, `FCIC_STAT_ADDR, 32'h0, q);
        check(q[0], 1'b1, "busy in status");
        creg(8'hD5, 8'h80, "flags after stall");
        xfer(1'b1, `FCIC_CMD_ADDR, {24'h0, `FCIC_OP_CINV}, q);
        run({16'h0, `FCIC_OP_CINV}, 4'h4, 2'h1);
        creg(8'hD5, 8'h80, "back to back flips");
        run({16'h0, 8'hFF}, 4'h4, 2'h0);
        creg(8'hD5, 8'h80, "unknown op flags");
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_carry();
        t_fill();
        t_invert();
        t_cmp();
        t_busy();
        give_verdict();
    end
endmodule // flag_clear_invert_compare_ops_tb
`default_nettype wire
